// ===== inc/twm_cfg.svh
`ifndef TWM_CFG_SVH
`define TWM_CFG_SVH
// Register indices (byte address = index * 4)
`define TWM_CTRL_A_IDX      4'h0
`define TWM_CTRL_B_IDX      4'h1
`define TWM_COUNT_IDX       4'h2
`define TWM_CMP_A_IDX       4'h3
`define TWM_CMP_B_IDX       4'h4
`define TWM_CAPT_IDX        4'h5
`define TWM_IRQ_STAT_IDX    4'h6
`define TWM_IRQ_MASK_IDX    4'h7
`define TWM_PIN_DIR_IDX     4'h8
// Field positions
`define TWM_COMA_HI         7
`define TWM_COMA_LO         6
`define TWM_COMB_HI         5
`define TWM_COMB_LO         4
`define TWM_WGM_LO_HI       1
`define TWM_WGM_LO_LO       0
`define TWM_WGM_HI_HI       4
`define TWM_WGM_HI_LO       3
`define TWM_CS_HI           2
`define TWM_CS_LO           0
`define TWM_ST_OVF          0
`define TWM_ST_CMA          1
`define TWM_ST_CMB          2
// Reset values and writable masks
`define TWM_CTRL_A_RST      8'h00
`define TWM_CTRL_B_RST      8'h00
`define TWM_CTRL_A_WMASK    8'hf3
`define TWM_CTRL_B_WMASK    8'h1f
// TOP values
`define TWM_TOP_MAX         16'hffff
`define TWM_TOP_8BIT        16'h00ff
`define TWM_TOP_9BIT        16'h01ff
`define TWM_TOP_10BIT       16'h03ff
// Prescale counts
`define TWM_DIV8_LAST       10'h007
`define TWM_DIV64_LAST      10'h03f
`define TWM_DIV256_LAST     10'h0ff
`define TWM_DIV1024_LAST    10'h3ff
`endif

// ===== inc/twm_pkg.sv
package twm_pkg;
   typedef logic [3:0]  twm_wgm_t;
   typedef logic [1:0]  twm_com_t;
   typedef logic [2:0]  twm_cs_t;
   typedef logic [15:0] twm_word_t;
   typedef enum logic [1:0] {
      TWM_KIND_NORMAL = 2'h0,
      TWM_KIND_FAST   = 2'h1,
      TWM_KIND_DUAL   = 2'h3
   } twm_kind_t;
endpackage

// ===== logic/twm_out_chan.sv
`timescale 1ns/1ps
`include "twm_cfg.svh"
// One compare output channel: match detect and pin action
module twm_out_chan
   import twm_pkg::*;
#(
   parameter bit IS_CHAN_A = 1'b1
) (
   // Clock, reset and enable
   input  wire logic            i_clock,
   input  wire logic            i_rst_b,
   input  wire logic            i_enable,
   // Timer state
   input  wire logic            i_tick,
   input  wire twm_pkg::twm_kind_t i_kind,
   input  wire twm_pkg::twm_wgm_t  i_wgm,
   input  wire twm_pkg::twm_com_t  i_mode,
   input  wire twm_pkg::twm_word_t i_count,
   input  wire twm_pkg::twm_word_t i_compare,
   input  wire twm_pkg::twm_word_t i_top,
   input  wire logic            i_at_top,
   input  wire logic            i_down,
   input  wire logic            i_blocked,
   input  wire logic            i_dir_out,
   // Results
   output logic                 o_match,
   output logic                 o_wave,
   output logic                 o_override,
   output logic                 o_drive_en
);
   import twm_pkg::*;

   logic wave_r;
   logic wave_nxt;
   wire  match_raw = i_tick && !i_blocked && (i_count == i_compare);
   // Non-PWM toggle serves both channels; PWM toggle is channel A only
   wire  toggle_ok = (i_kind == TWM_KIND_NORMAL) || (IS_CHAN_A && (
                     (i_kind == TWM_KIND_FAST && i_wgm[3:1] == 3'h7) ||
                     (i_kind == TWM_KIND_DUAL && i_wgm[3:2] == 2'h2)));
   // Match at TOP ignored; TOP action alone
   wire  fast_skip = (i_kind == TWM_KIND_FAST) && i_mode[1] && (i_compare == i_top);
   wire  act_match = match_raw && !fast_skip;
   wire  act_top   = i_tick && (i_kind == TWM_KIND_FAST) && i_at_top && i_mode[1];

   assign o_match    = match_raw;
   assign o_override = |i_mode;
   assign o_drive_en = o_override && i_dir_out;
   assign o_wave     = wave_r;

   always_comb begin
      wave_nxt = wave_r;
      unique case (i_mode)
         2'h0: wave_nxt = wave_r;
         2'h1: if (act_match && toggle_ok) begin
            wave_nxt = !wave_r;
         end
         2'h2: if (i_kind == TWM_KIND_DUAL) begin
            if (act_match) begin
               wave_nxt = i_down;
            end
         end else if (i_kind == TWM_KIND_FAST) begin
            if (act_top) begin
               wave_nxt = 1'b1;
            end else if (act_match) begin
               wave_nxt = 1'b0;
            end
         end else if (act_match) begin
            wave_nxt = 1'b0;
         end
         2'h3: if (i_kind == TWM_KIND_DUAL) begin
            if (act_match) begin
               wave_nxt = !i_down;
            end
         end else if (i_kind == TWM_KIND_FAST) begin
            if (act_top) begin
               wave_nxt = 1'b0;
            end else if (act_match) begin
               wave_nxt = 1'b1;
            end
         end else if (act_match) begin
            wave_nxt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wave_r <= 1'b0;
      end else if (i_enable) begin
         wave_r <= wave_nxt;
      end
   end

   disable_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_mode == 2'h0) |-> !o_override && !o_drive_en)
      else $error("Output driven while disconnected");
   no_tick_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_enable && !i_tick) |=> $stable(wave_r))
      else $error("Wave changed without tick");
endmodule

// ===== logic/twm_timer.sv
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "twm_cfg.svh"
module twm_timer
   import twm_pkg::*;
(
   // Clock, reset, enable
   input  wire logic            i_clock,
   input  wire logic            i_rst_b,
   input  wire logic            i_enable,
   // Register port
   input  wire logic [7:0]      i_addr,
   input  wire logic [31:0]     i_wdata,
   input  wire logic            i_write,
   input  wire logic            i_read,
   output logic [31:0]          o_rdata,
   // External count pin
   input  wire logic            i_ext_pin,
   // Waveform pins
   output logic                 o_chan_a_wave_out,
   output logic                 o_chan_a_wave_oe,
   output logic                 o_chan_a_override,
   output logic                 o_chan_b_wave_out,
   output logic                 o_chan_b_wave_oe,
   output logic                 o_chan_b_override,
   // Interrupt
   output logic                 o_irq
);
   import twm_pkg::*;

   // ****************************************************
   // Register file
   // ****************************************************
   logic [7:0]  ctrl_a_r;
   logic [7:0]  ctrl_b_r;
   logic [15:0] count_r;
   logic [15:0] count_nxt;
   logic [15:0] cmp_a_buf_r;
   logic [15:0] cmp_b_buf_r;
   logic [15:0] cmp_a_r;
   logic [15:0] cmp_b_r;
   logic [15:0] capt_r;
   logic [2:0]  stat_r;
   logic [2:0]  mask_r;
   logic [1:0]  dir_r;
   logic        down_r;
   logic        blocked_r;
   logic [31:0] rdata_r;
   logic [9:0]  presc_r;
   logic [2:0]  pin_sync_r;

   wire [3:0] idx     = i_addr[5:2];
   wire       aligned = (i_addr[1:0] == 2'h0) && (i_addr[7:6] == 2'h0);
   wire       wr      = i_write && aligned;
   wire       wr_ca   = wr && idx == `TWM_CTRL_A_IDX;
   wire       wr_cb   = wr && idx == `TWM_CTRL_B_IDX;
   wire       wr_cnt  = wr && idx == `TWM_COUNT_IDX;
   wire       wr_oa   = wr && idx == `TWM_CMP_A_IDX;
   wire       wr_ob   = wr && idx == `TWM_CMP_B_IDX;
   wire       wr_cap  = wr && idx == `TWM_CAPT_IDX;
   wire       wr_st   = wr && idx == `TWM_IRQ_STAT_IDX;
   wire       wr_mk   = wr && idx == `TWM_IRQ_MASK_IDX;
   wire       wr_dir  = wr && idx == `TWM_PIN_DIR_IDX;

   // ****************************************************
   // Mode decode
   // ****************************************************
   wire twm_wgm_t  wgm = {ctrl_b_r[`TWM_WGM_HI_HI:`TWM_WGM_HI_LO],
                          ctrl_a_r[`TWM_WGM_LO_HI:`TWM_WGM_LO_LO]};
   wire twm_cs_t   cs  = ctrl_b_r[`TWM_CS_HI:`TWM_CS_LO];
   wire twm_com_t  com_a = ctrl_a_r[`TWM_COMA_HI:`TWM_COMA_LO];
   wire twm_com_t  com_b = ctrl_a_r[`TWM_COMB_HI:`TWM_COMB_LO];

   wire is_fast  = (wgm[3:0] >= 4'h5 && wgm <= 4'h7) || wgm == 4'he || wgm == 4'hf;
   wire is_dual  = (wgm >= 4'h1 && wgm <= 4'h3) || (wgm >= 4'h8 && wgm <= 4'hb);
   wire is_pfc   = wgm == 4'h8 || wgm == 4'h9;
   wire twm_kind_t kind = is_fast ? TWM_KIND_FAST :
                          (is_dual ? TWM_KIND_DUAL : TWM_KIND_NORMAL);
   // Immediate-update modes: 0, 4, 12 and reserved 13
   wire immediate = !is_fast && !is_dual;

   logic [15:0] top;
   always_comb begin
      unique case (wgm)
         4'h1, 4'h5: top = `TWM_TOP_8BIT;
         4'h2, 4'h6: top = `TWM_TOP_9BIT;
         4'h3, 4'h7: top = `TWM_TOP_10BIT;
         4'h4, 4'h9, 4'hb, 4'hf: top = cmp_a_r;
         4'h8, 4'ha, 4'hc, 4'he: top = capt_r;
         default: top = `TWM_TOP_MAX;
      endcase
   end

   // ****************************************************
   // Tick source
   // ****************************************************
   // Pin crosses two flops; third stage feeds the edge detector
   wire ext_rise = pin_sync_r[1] && !pin_sync_r[2];
   wire ext_fall = !pin_sync_r[1] && pin_sync_r[2];
   logic tick;
   always_comb begin
      unique case (cs)
         3'h0: tick = 1'b0;
         3'h1: tick = 1'b1;
         3'h2: tick = presc_r[2:0] == 3'(`TWM_DIV8_LAST);
         3'h3: tick = presc_r[5:0] == 6'(`TWM_DIV64_LAST);
         3'h4: tick = presc_r[7:0] == 8'(`TWM_DIV256_LAST);
         3'h5: tick = presc_r == `TWM_DIV1024_LAST;
         3'h6: tick = ext_fall;
         3'h7: tick = ext_rise;
      endcase
   end

   // ****************************************************
   // Counter
   // ****************************************************
   wire at_top    = count_r == top;
   wire at_bottom = count_r == 16'h0000;
   wire at_max    = count_r == `TWM_TOP_MAX;
   wire ctc_mode  = wgm == 4'h4 || wgm == 4'hc;
   wire down_now  = is_dual && (down_r || at_top) && !at_bottom;

   always_comb begin
      count_nxt = count_r + 16'h0001;
      if (is_dual) begin
         count_nxt = down_now ? count_r - 16'h0001 : count_r + 16'h0001;
      end else if ((is_fast || ctc_mode) && at_top) begin
         count_nxt = 16'h0000;
      end
   end

   // Flag and update points, only on ticks
   wire ovf_ev  = tick && !blocked_r && ((is_fast && at_top) ||
                  (is_dual && at_bottom) ||
                  (immediate && at_max));
   wire upd_ev  = tick && (is_pfc ? at_bottom : at_top);
   wire match_a;
   wire match_b;

   // ****************************************************
   // Output channels
   // ****************************************************
   twm_out_chan #(.IS_CHAN_A(1'b1)) u_chan_a (
      .i_clock    (i_clock),
      .i_rst_b    (i_rst_b),
      .i_enable   (i_enable),
      .i_tick     (tick),
      .i_kind     (kind),
      .i_wgm      (wgm),
      .i_mode     (com_a),
      .i_count    (count_r),
      .i_compare  (cmp_a_r),
      .i_top      (top),
      .i_at_top   (at_top),
      .i_down     (down_now),
      .i_blocked  (blocked_r),
      .i_dir_out  (dir_r[0]),
      .o_match    (match_a),
      .o_wave     (o_chan_a_wave_out),
      .o_override (o_chan_a_override),
      .o_drive_en (o_chan_a_wave_oe)
   );
   twm_out_chan #(.IS_CHAN_A(1'b0)) u_chan_b (
      .i_clock    (i_clock),
      .i_rst_b    (i_rst_b),
      .i_enable   (i_enable),
      .i_tick     (tick),
      .i_kind     (kind),
      .i_wgm      (wgm),
      .i_mode     (com_b),
      .i_count    (count_r),
      .i_compare  (cmp_b_r),
      .i_top      (top),
      .i_at_top   (at_top),
      .i_down     (down_now),
      .i_blocked  (blocked_r),
      .i_dir_out  (dir_r[1]),
      .o_match    (match_b),
      .o_wave     (o_chan_b_wave_out),
      .o_override (o_chan_b_override),
      .o_drive_en (o_chan_b_wave_oe)
   );

   wire [2:0] events  = {match_b, match_a, ovf_ev};
   wire [2:0] clr_st  = wr_st ? i_wdata[2:0] : 3'h0;
   // Set wins over a same-cycle clear
   wire [2:0] stat_nxt = (stat_r & ~clr_st) | events;
   assign o_irq = |(stat_r & mask_r);

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (idx)
         `TWM_CTRL_A_IDX:   rd_mux[7:0]  = ctrl_a_r;
         `TWM_CTRL_B_IDX:   rd_mux[7:0]  = ctrl_b_r;
         `TWM_COUNT_IDX:    rd_mux[15:0] = count_r;
         `TWM_CMP_A_IDX:    rd_mux[15:0] = immediate ? cmp_a_r : cmp_a_buf_r;
         `TWM_CMP_B_IDX:    rd_mux[15:0] = immediate ? cmp_b_r : cmp_b_buf_r;
         `TWM_CAPT_IDX:     rd_mux[15:0] = capt_r;
         `TWM_IRQ_STAT_IDX: rd_mux[2:0]  = stat_r;
         `TWM_IRQ_MASK_IDX: rd_mux[2:0]  = mask_r;
         `TWM_PIN_DIR_IDX:  rd_mux[1:0]  = dir_r;
         default:           rd_mux       = 32'h0000_0000;
      endcase
      if (!aligned) begin
         rd_mux = 32'h0000_0000;
      end
   end
   assign o_rdata = rdata_r;

   // ****************************************************
   // State
   // ****************************************************
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_a_r    <= `TWM_CTRL_A_RST;
         ctrl_b_r    <= `TWM_CTRL_B_RST;
         mask_r      <= 3'h0;
         dir_r       <= 2'h0;
         capt_r      <= 16'h0000;
         rdata_r     <= 32'h0000_0000;
         stat_r      <= 3'h0;
         presc_r     <= 10'h000;
         pin_sync_r  <= 3'h0;
      end else if (i_enable) begin
         if (wr_ca) ctrl_a_r <= i_wdata[7:0] & `TWM_CTRL_A_WMASK;
         if (wr_cb) ctrl_b_r <= i_wdata[7:0] & `TWM_CTRL_B_WMASK;
         if (wr_mk) mask_r <= i_wdata[2:0];
         if (wr_dir) dir_r <= i_wdata[1:0];
         if (wr_cap) capt_r <= i_wdata[15:0];
         rdata_r    <= i_read ? rd_mux : 32'h0000_0000;
         stat_r     <= stat_nxt;
         presc_r    <= presc_r + 10'h001;
         pin_sync_r <= {pin_sync_r[1:0], i_ext_pin};
      end
   end

   // Counter and compare buffers; tick acts as enable only
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         count_r     <= 16'h0000;
         down_r      <= 1'b0;
         blocked_r   <= 1'b0;
         cmp_a_buf_r <= 16'h0000;
         cmp_b_buf_r <= 16'h0000;
         cmp_a_r     <= 16'h0000;
         cmp_b_r     <= 16'h0000;
      end else if (i_enable) begin
         if (wr_oa) cmp_a_buf_r <= i_wdata[15:0];
         if (wr_ob) cmp_b_buf_r <= i_wdata[15:0];
         if (wr_oa && immediate) begin
            cmp_a_r <= i_wdata[15:0];
         end else if (upd_ev && !immediate) begin
            cmp_a_r <= cmp_a_buf_r;
         end
         if (wr_ob && immediate) begin
            cmp_b_r <= i_wdata[15:0];
         end else if (upd_ev && !immediate) begin
            cmp_b_r <= cmp_b_buf_r;
         end
         if (wr_cnt) begin
            count_r   <= i_wdata[15:0];
            blocked_r <= 1'b1;
         end else if (tick) begin
            count_r   <= count_nxt;
            down_r    <= down_now;
            blocked_r <= 1'b0;
         end
      end
   end

   irq_level_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_enable && |(events & mask_r) && !wr_mk) |=> o_irq)
      else $error("Unmasked event did not raise interrupt");
   stop_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_enable && cs == 3'h0 && !wr_cnt) |=> $stable(count_r))
      else $error("Counter moved while stopped");
   fast_ovf_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_enable && tick && is_fast && at_top && !blocked_r) |=> stat_r[`TWM_ST_OVF])
      else $error("Fast PWM overflow flag missed at TOP");
   dual_ovf_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_enable && tick && is_dual && at_bottom && !blocked_r) |=> stat_r[`TWM_ST_OVF])
      else $error("Dual-slope overflow flag missed at BOTTOM");
   norm_ovf_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_enable && wgm == 4'h0 && tick && at_max && !blocked_r) |=> stat_r[`TWM_ST_OVF])
      else $error("Normal overflow flag missed at MAX");
   pfc_update_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_enable && is_pfc && tick && at_bottom && !wr_oa) |=> cmp_a_r == $past(cmp_a_buf_r))
      else $error("Compare not loaded at BOTTOM");
   no_tick_flag_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (!tick) |-> (events == 3'h0))
      else $error("Event without tick");
   mode_form_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_enable && wr_cb) |=> (wgm == {$past(i_wdata[`TWM_WGM_HI_HI:`TWM_WGM_HI_LO]),
                                       $past(ctrl_a_r[`TWM_WGM_LO_HI:`TWM_WGM_LO_LO])}))
      else $error("Mode field misassembled");
   pin_gate_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      o_chan_a_wave_oe |-> (dir_r[0] && o_chan_a_override))
      else $error("Channel A driven without direction");
   fast_b_tog_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
      (i_enable && com_b == 2'h1 && !is_dual && !immediate) |=> $stable(o_chan_b_wave_out))
      else $error("Channel B toggled in fast PWM");
endmodule

// ===== verif/twm_timer_test.sv
`timescale 1ns/1ps
`include "twm_cfg.svh"
module twm_timer_test;
   import twm_pkg::*;
   // ******
   // Design and drive
   // ******
   localparam logic [3:0] CA = `TWM_CTRL_A_IDX;
   localparam logic [3:0] CB = `TWM_CTRL_B_IDX;
   localparam logic [3:0] ST = `TWM_IRQ_STAT_IDX;
   logic        i_clock;
   logic        i_rst_b;
   logic        i_enable;
   logic [7:0]  i_addr;
   logic [31:0] i_wdata;
   logic        i_write;
   logic        i_read;
   logic        i_ext_pin;
   logic [31:0] o_rdata;
   logic        o_chan_a_wave_out;
   logic        o_chan_a_wave_oe;
   logic        o_chan_a_override;
   logic        o_chan_b_wave_out;
   logic        o_chan_b_wave_oe;
   logic        o_chan_b_override;
   logic        o_irq;
   logic [31:0] exp_q[$];
   logic [31:0] exp_v;
   logic        rd_d;
   logic [1:0]  ext_cnt;
   int          error_cnt;
   int          n_compared;
   int          cyc;
   int          seed;
   twm_timer dut (
      .i_clock(i_clock), .i_rst_b(i_rst_b), .i_enable(i_enable),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
      .o_rdata(o_rdata), .i_ext_pin(i_ext_pin),
      .o_chan_a_wave_out(o_chan_a_wave_out), .o_chan_a_wave_oe(o_chan_a_wave_oe),
      .o_chan_a_override(o_chan_a_override), .o_chan_b_wave_out(o_chan_b_wave_out),
      .o_chan_b_wave_oe(o_chan_b_wave_oe), .o_chan_b_override(o_chan_b_override),
      .o_irq(o_irq)
   );
   always #2.5 i_clock = ~i_clock;
   // Free-running pin: one edge of each kind every 4 cycles
   always @(posedge i_clock) begin
      ext_cnt <= ext_cnt + 2'd1;
      i_ext_pin <= ext_cnt[1];
   end
   task automatic end_sim;
      if (error_cnt == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Cycle ceiling well above the longest sequence
   always @(posedge i_clock) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         error_cnt++;
         end_sim();
      end
   end
   // Read results land one cycle after the strobe
   always @(posedge i_clock) begin
      rd_d <= i_read;
      if (rd_d === 1'b1) begin
         exp_v = exp_q.pop_front();
         chk(o_rdata, exp_v);
      end
   end
   task automatic wr(input logic [3:0] idx, input logic [31:0] d);
      @(posedge i_clock);
      i_addr <= {2'b00, idx, 2'b00};
      i_wdata <= d;
      i_write <= 1'b1;
      @(posedge i_clock);
      i_write <= 1'b0;
   endtask
   task automatic rda(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_clock);
      i_addr <= a;
      i_read <= 1'b1;
      exp_q.push_back(e);
      @(posedge i_clock);
      i_read <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] idx, input logic [31:0] e);
      rda({2'b00, idx, 2'b00}, e);
   endtask
   task automatic setup(input twm_wgm_t w, input twm_com_t ca, input twm_com_t cb,
                        input logic [15:0] cpa, input logic [15:0] cpb, input twm_cs_t cs);
      wr(CB, 32'h0);
      wr(CA, 32'h0);
      wr(`TWM_COUNT_IDX, 32'h0);
      wr(`TWM_CMP_A_IDX, {16'h0, cpa});
      wr(`TWM_CMP_B_IDX, {16'h0, cpb});
      wr(`TWM_CAPT_IDX, {16'h0, cpa});
      wr(CA, {24'h0, ca, cb, 2'b00, w[1:0]});
      wr(CB, {27'h0, w[3:2], cs});
   endtask
   // High samples of B and level changes of both outputs over n cycles
   task automatic meas(input int n, output int hb, output int ta, output int tb);
      logic pa;
      logic pb;
      hb = 0;
      ta = 0;
      tb = 0;
      @(posedge i_clock);
      #1;
      pa = o_chan_a_wave_out;
      pb = o_chan_b_wave_out;
      repeat (n) begin
         @(posedge i_clock);
         #1;
         hb += int'(o_chan_b_wave_out === 1'b1);
         ta += int'(o_chan_a_wave_out !== pa);
         tb += int'(o_chan_b_wave_out !== pb);
         pa = o_chan_a_wave_out;
         pb = o_chan_b_wave_out;
      end
   endtask
   // ******
   // Sequence
   // ******
   int modes[12] = '{1, 2, 3, 8, 9, 10, 11, 5, 6, 7, 14, 15};
   int hb, ta, tb, w, top, per, eh, cmpb;
   logic [1:0] dir;
   bit dual;
   initial begin
      i_clock = 1'b0;
      i_rst_b = 1'b0;
      i_enable = 1'b1;
      i_addr = 8'h00;
      i_wdata = 32'h0;
      i_write = 1'b0;
      i_read = 1'b0;
      i_ext_pin = 1'b0;
      ext_cnt = 2'd0;
      rd_d = 1'b0;
      error_cnt = 0;
      n_compared = 0;
      cyc = 0;
      seed = 32'h4f4d;
      repeat (12) @(posedge i_clock);
      i_rst_b <= 1'b1;
      rd(CA, 32'h0);
      rd(CB, 32'h0);
      rd(ST, 32'h0);
      rda(8'h24, 32'h0);
      rda(8'h01, 32'h0);
      wr(CA, 32'hff);
      rd(CA, {24'h0, `TWM_CTRL_A_WMASK});
      wr(CB, 32'hf8);
      rd(CB, 32'h18);
      for (int i = 0; i < 16; i++) begin
         dir = 2'($random(seed));
         wr(`TWM_PIN_DIR_IDX, {30'h0, dir});
         wr(CA, {24'h0, 4'(i), 4'h0});
         #1;
         chk(o_chan_a_override, i[3:2] != 2'b00);
         chk(o_chan_b_override, i[1:0] != 2'b00);
         chk(o_chan_a_wave_oe, i[3:2] != 2'b00 && dir[0]);
         chk(o_chan_b_wave_oe, i[1:0] != 2'b00 && dir[1]);
      end
      setup(4'd4, 2'b01, 2'b11, 16'h3, 16'h1, 3'd1);
      repeat (8) @(posedge i_clock);
      meas(16, hb, ta, tb);
      chk(ta, 4);
      chk(hb, 16);
      wr(CA, 32'h60);
      repeat (8) @(posedge i_clock);
      meas(16, hb, ta, tb);
      chk(hb, 0);
      setup(4'd12, 2'b01, 2'b01, 16'h3, 16'h1, 3'd0);
      wr(CB, 32'h19);
      repeat (8) @(posedge i_clock);
      meas(16, hb, ta, tb);
      chk(ta, 4);
      chk(tb, 4);
      // Enable low must freeze both outputs
      @(posedge i_clock);
      i_enable <= 1'b0;
      meas(16, hb, ta, tb);
      chk(ta + tb, 0);
      @(posedge i_clock);
      i_enable <= 1'b1;
      setup(4'd0, 2'b00, 2'b00, 16'h1234, 16'h1234, 3'd0);
      wr(`TWM_COUNT_IDX, 32'hfffd);
      wr(ST, 32'h7);
      wr(`TWM_IRQ_MASK_IDX, 32'h1);
      rd(ST, 32'h0);
      wr(CB, 32'h1);
      repeat (8) @(posedge i_clock);
      wr(CB, 32'h0);
      rd(ST, 32'h1);
      #1;
      chk(o_irq, 1'b1);
      wr(ST, 32'h1);
      #1;
      chk(o_irq, 1'b0);
      for (int k = 0; k < 24; k++) begin
         w = modes[k % 12];
         top = (w == 1 || w == 5) ? 255 : (w == 2 || w == 6) ? 511 : (w == 3 || w == 7) ? 1023 : 7;
         dual = (w < 4) || (w >= 8 && w < 12);
         cmpb = top / 2;
         setup(4'(w), 2'b01, (k < 12) ? 2'b10 : 2'b11, 16'h7, 16'(cmpb), 3'd1);
         per = dual ? 2 * top : top + 1;
         repeat (per + 4) @(posedge i_clock);
         meas(2 * per, hb, ta, tb);
         eh = dual ? 4 * cmpb : 2 * (cmpb + 1);
         if (k >= 12) begin
            eh = 2 * per - eh;
         end
         chk(hb, eh);
         chk(ta, (w >= 8) ? 2 : 0);
      end
      setup(4'd15, 2'b00, 2'b10, 16'h7, 16'h7, 3'd1);
      repeat (12) @(posedge i_clock);
      meas(16, hb, ta, tb);
      chk(hb, 16);
      setup(4'd15, 2'b00, 2'b01, 16'h7, 16'h3, 3'd1);
      repeat (12) @(posedge i_clock);
      meas(16, hb, ta, tb);
      chk(tb, 0);
      // Slower ticks stretch the same waveform by the tick spacing
      for (int c = 0; c < 6; c++) begin
         setup(4'd15, 2'b01, 2'b10, 16'h7, 16'h3, 3'(c + 2));
         per = (c == 0) ? 64 : (c == 1) ? 512 : (c == 2) ? 2048 : (c == 3) ? 8192 : 32;
         repeat (per + 16) @(posedge i_clock);
         meas(2 * per, hb, ta, tb);
         chk(ta, 2);
         chk(hb, per);
      end
      repeat (4) @(posedge i_clock);
      end_sim();
   end
endmodule
